/* hw/bfbi_pkg.sv */
package bfbi_pkg;

  // ------------------------------------------------------------------
  // Latency settings
  // ------------------------------------------------------------------
  localparam logic [2:0] BFBI_LAT_ONE     = 3'h1;
  localparam logic [2:0] BFBI_LAT_TWO     = 3'h2;
  localparam logic [2:0] BFBI_LAT_INITIAL = 3'h4;

  // ------------------------------------------------------------------
  // Burst geometry
  // ------------------------------------------------------------------
  localparam int BFBI_CNT_W_WIDE   = 3;
  localparam int BFBI_CNT_W_NARROW = 2;
  localparam int BFBI_ADDR_LSB     = 2;

  // ------------------------------------------------------------------
  // Timing in cycles
  // ------------------------------------------------------------------
  localparam logic [3:0] BFBI_WE_CYCLES      = 4'h4;
  localparam logic [3:0] BFBI_INIT_FIRST     = 4'h5;
  localparam logic [3:0] BFBI_INIT_NEXT      = 4'h1;
  localparam logic [3:0] BFBI_OPT_FIRST      = 4'h3;
  localparam logic [3:0] BFBI_OPT_FIRST_SLOW = 4'h2;

  typedef enum logic [2:0] {
    BFBI_IDLE,
    BFBI_RD_ADDR,
    BFBI_RD_WAIT,
    BFBI_RD_BEAT,
    BFBI_WR_ADDR,
    BFBI_WR_PULSE,
    BFBI_WR_HOLD
  } bfbi_state_type;

endpackage

/* hw/bfbi_top.sv */
`timescale 1ns/1ps
// What this block does
// - Latency two: strobe held, counter advances thrice
// - Optimized read gives 3-0-0-0 word pattern
// - Other signals behave as initial read
// - Write holds address through each pulse; counter steps between beats
// - At 16 MHz latency setting is one
// - 16 MHz: acknowledge one clock earlier
// - Burst-last input ends burst when present
// - Without burst-last, length from address bits
// - 32-bit bus served by one matching device
// - Two-bit counter for four-beat bursts
// - Counter loads address bits three, two
// - No flash select: return to idle
// - Burst-last sampled: end read, go idle
// - Reset latency gives 5-1-1-1 reads
module bfbi_top
  import bfbi_pkg::*;
#(
  parameter int CNT_W        = BFBI_CNT_W_NARROW,
  parameter bit HAS_LAST     = 1'b1,
  parameter bit SLOW_CLOCK   = 1'b0,
  parameter int DATA_W       = 32
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Processor bus, same clock
  input  wire logic              cycle_start_strobe_n,
  input  wire logic              write_not_read,
  input  wire logic              last_beat_flag_n,
  input  wire logic              flash_select_n,
  input  wire logic [CNT_W+1:0]  proc_addr_low,
  input  wire logic [2:0]        burst_latency_setting,
  // Flash data returned
  input  wire logic [DATA_W-1:0] flash_data,
  // Flash strobes
  output logic                   address_valid_strobe_n,
  output logic [CNT_W-1:0]       burst_count_bits,
  output logic                   output_enable_n,
  output logic                   write_enable_n,
  output logic                   data_path_selector,
  // Read stream to processor
  output logic                   beat_acknowledge_n,
  output logic [DATA_W-1:0]      read_data,
  input  wire logic              read_ready
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  bfbi_state_type          state_reg;
  logic [3:0]              wait_reg;
  logic [CNT_W-1:0]        remain_reg;
  logic [CNT_W:0]          issued_reg;
  logic                    optimized_reg;
  logic                    fetch_done_reg;
  logic                    beat_due;
  logic                    in_ready;
  logic                    pop;
  logic                    final_pop;
  logic                    fetch_last;
  logic                    adv_next;
  logic                    wr_active;
  logic [1:0]              buf_valid_reg;
  logic [DATA_W-1:0]       buf_data_reg [2];

  wire start = !cycle_start_strobe_n;
  wire [CNT_W:0] burst_len = (CNT_W+1)'(1) << CNT_W;

  // ------------------------------------------------------------------
  // Handshake decode
  // ------------------------------------------------------------------
  always_comb begin
    in_ready = !buf_valid_reg[1];
  end

  always_comb begin
    pop = buf_valid_reg[0] && read_ready;
  end

  // Burst-last travels with the final word's acknowledge; the buffer
  // runs ahead of the processor, so fetching alone cannot end a burst
  always_comb begin
    final_pop = HAS_LAST && (state_reg == BFBI_RD_BEAT) && pop && !last_beat_flag_n;
  end

  always_comb begin
    fetch_last = (remain_reg == '0);
  end

  always_comb begin
    beat_due = (state_reg == BFBI_RD_BEAT) && (wait_reg == 4'h0) && in_ready &&
               !fetch_done_reg && !final_pop;
  end

  always_comb begin
    wr_active = (state_reg == BFBI_WR_ADDR) || (state_reg == BFBI_WR_PULSE) ||
                (state_reg == BFBI_WR_HOLD);
  end

  // ------------------------------------------------------------------
  // Main state machine
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= BFBI_IDLE;
    end else begin
      unique case (state_reg)
        BFBI_IDLE: begin
          if (start && write_not_read) begin
            state_reg <= BFBI_WR_ADDR;
          end else if (start) begin
            state_reg <= BFBI_RD_ADDR;
          end
        end
        BFBI_RD_ADDR: begin
          state_reg <= flash_select_n ? BFBI_IDLE : BFBI_RD_BEAT;
        end
        BFBI_RD_BEAT: begin
          if (final_pop) begin
            state_reg <= BFBI_IDLE;
          end else if (!HAS_LAST && beat_due && fetch_last) begin
            state_reg <= BFBI_IDLE;
          end
        end
        BFBI_WR_ADDR: begin
          state_reg <= flash_select_n ? BFBI_IDLE : BFBI_WR_PULSE;
        end
        BFBI_WR_PULSE: begin
          if (wait_reg == 4'h0) begin
            state_reg <= BFBI_WR_HOLD;
          end
        end
        BFBI_WR_HOLD: begin
          state_reg <= last_beat_flag_n ? BFBI_WR_PULSE : BFBI_IDLE;
        end
        default: begin
          state_reg <= BFBI_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Wait counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        BFBI_RD_ADDR: begin
          if (!optimized_reg) begin
            wait_reg <= BFBI_INIT_FIRST - 4'h1;
          end else if (SLOW_CLOCK) begin
            wait_reg <= BFBI_OPT_FIRST_SLOW - 4'h1;
          end else begin
            wait_reg <= BFBI_OPT_FIRST - 4'h1;
          end
        end
        BFBI_RD_BEAT: begin
          if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
          end else if (beat_due) begin
            wait_reg <= optimized_reg ? 4'h0 : BFBI_INIT_NEXT;
          end
        end
        BFBI_WR_ADDR, BFBI_WR_HOLD: begin
          wait_reg <= BFBI_WE_CYCLES - 4'h1;
        end
        BFBI_WR_PULSE: begin
          if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
          end
        end
        default: begin
          wait_reg <= wait_reg;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Fetch length
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain_reg <= '0;
    end else if (state_reg == BFBI_IDLE && start && !write_not_read) begin
      // Length from address bits where no burst-last exists
      remain_reg <= HAS_LAST ? CNT_W'('1) :
                    ~proc_addr_low[CNT_W+1:BFBI_ADDR_LSB];
    end else if (beat_due && !fetch_last) begin
      remain_reg <= remain_reg - CNT_W'(1);
    end
  end

  // Never fetch past one full burst, even if burst-last comes late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_done_reg <= 1'b0;
    end else if (state_reg == BFBI_IDLE) begin
      fetch_done_reg <= 1'b0;
    end else if (beat_due && fetch_last) begin
      fetch_done_reg <= 1'b1;
    end
  end

  // Latency sampled per transaction, so a change never splits a burst
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      optimized_reg <= 1'b0;
    end else if (state_reg == BFBI_IDLE) begin
      optimized_reg <= (burst_latency_setting == BFBI_LAT_TWO) ||
                       (burst_latency_setting == BFBI_LAT_ONE);
    end
  end

  // ------------------------------------------------------------------
  // Burst counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burst_count_bits <= '0;
      issued_reg       <= '0;
    end else if (state_reg == BFBI_IDLE && start) begin
      burst_count_bits <= proc_addr_low[CNT_W+1:BFBI_ADDR_LSB];
      issued_reg       <= '0;
    end else if (state_reg == BFBI_RD_BEAT && optimized_reg) begin
      // Optimized: advance every cycle until the burst's last address, for back-to-back accesses
      if (issued_reg < burst_len - (CNT_W+1)'(1)) begin
        burst_count_bits <= burst_count_bits + CNT_W'(1);
        issued_reg       <= issued_reg + (CNT_W+1)'(1);
      end
    end else if (beat_due || (state_reg == BFBI_WR_HOLD && last_beat_flag_n)) begin
      burst_count_bits <= burst_count_bits + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Flash strobes
  // ------------------------------------------------------------------
  // Optimized mode holds strobe low from start; initial mode gaps it
  always_comb begin
    adv_next = (state_reg == BFBI_IDLE && start && !write_not_read) ||
               (state_reg == BFBI_RD_ADDR && !flash_select_n && optimized_reg) ||
               (state_reg == BFBI_RD_BEAT && optimized_reg &&
                issued_reg < burst_len - (CNT_W+1)'(1)) ||
               (beat_due && !optimized_reg);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      address_valid_strobe_n <= 1'b1;
    end else begin
      address_valid_strobe_n <= !adv_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_enable_n <= 1'b1;
      write_enable_n  <= 1'b1;
    end else begin
      output_enable_n <= !(state_reg == BFBI_RD_BEAT);
      write_enable_n  <= !(state_reg == BFBI_WR_PULSE && wait_reg != 4'h0);
    end
  end

  // Address held through each write pulse, stepped between beats; selector high for whole write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_path_selector <= 1'b0;
    end else begin
      data_path_selector <= wr_active;
    end
  end

  // ------------------------------------------------------------------
  // Two-entry read buffer and acknowledge
  // ------------------------------------------------------------------
  // Read data width matches bus width, one device per bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_valid_reg <= 2'h0;
    end else if (final_pop) begin
      // Words fetched past the final beat are dropped here
      buf_valid_reg <= 2'h0;
    end else if (pop) begin
      buf_valid_reg <= {1'b0, buf_valid_reg[1] | beat_due};
    end else if (beat_due) begin
      buf_valid_reg <= {buf_valid_reg[0], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_data_reg[0] <= '0;
      buf_data_reg[1] <= '0;
    end else if (pop) begin
      buf_data_reg[0] <= buf_data_reg[1];
      if (beat_due) begin
        buf_data_reg[buf_valid_reg[1]] <= flash_data;
      end
    end else if (beat_due) begin
      buf_data_reg[buf_valid_reg[0]] <= flash_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      beat_acknowledge_n <= 1'b1;
      read_data          <= '0;
    end else begin
      beat_acknowledge_n <= !pop;
      if (pop) begin
        read_data <= buf_data_reg[0];
      end
    end
  end

endmodule

/* tb/bfbi_checker.sv */
`timescale 1ns/1ps
module bfbi_checker
  import bfbi_pkg::*;
#(
  parameter int CNT_W = BFBI_CNT_W_NARROW
) (
  // Processor side
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             cycle_start_strobe_n,
  input wire logic             write_not_read,
  input wire logic             flash_select_n,
  input wire logic             read_ready,
  input wire logic [2:0]       burst_latency_setting,
  // Flash side
  input wire logic             address_valid_strobe_n,
  input wire logic [CNT_W-1:0] burst_count_bits,
  input wire logic             output_enable_n,
  input wire logic             write_enable_n,
  input wire logic             data_path_selector,
  input wire logic             beat_acknowledge_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_idle: assert property (disable iff (1'b0)
    !rst_n |=> address_valid_strobe_n && beat_acknowledge_n && write_enable_n)
    else $error("strobes active after reset");
  a_write_select: assert property (!write_enable_n |-> data_path_selector)
    else $error("selector low during write");
  a_write_hold: assert property (
    !write_enable_n && !$past(write_enable_n) |-> $stable(burst_count_bits))
    else $error("address moved during write pulse");
  a_we_width: assert property (
    $fell(write_enable_n) |-> !write_enable_n [*3] ##1 write_enable_n)
    else $error("write pulse width wrong");
  a_count_step: assert property (
    $changed(burst_count_bits) && !$past(output_enable_n) && !output_enable_n
    |-> burst_count_bits == CNT_W'($past(burst_count_bits) + 1'b1))
    else $error("counter did not step by one");
  a_adv_on_read: assert property (
    !cycle_start_strobe_n && !write_not_read |=> ##[0:1] !address_valid_strobe_n)
    else $error("no address strobe after read start");
  a_adv_held: assert property (
    $fell(address_valid_strobe_n) && burst_latency_setting == BFBI_LAT_TWO
    |-> !address_valid_strobe_n [*4])
    else $error("address strobe gap in latency two");
  a_abort_quiet: assert property (
    !cycle_start_strobe_n && !write_not_read ##1 flash_select_n |=> beat_acknowledge_n [*8])
    else $error("acknowledge after unselected start");
  a_first_ack: assert property (
    !cycle_start_strobe_n && !write_not_read ##1 !flash_select_n
    |-> ##[1:12] (!beat_acknowledge_n || !read_ready))
    else $error("first word late");
endmodule

bind bfbi_top bfbi_checker #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .cycle_start_strobe_n(cycle_start_strobe_n), .write_not_read(write_not_read),
  .flash_select_n(flash_select_n), .read_ready(read_ready),
  .burst_latency_setting(burst_latency_setting),
  .address_valid_strobe_n(address_valid_strobe_n), .burst_count_bits(burst_count_bits),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .data_path_selector(data_path_selector), .beat_acknowledge_n(beat_acknowledge_n));

/* tb/bfbi_flash_model.sv */
`timescale 1ns/1ps
module bfbi_flash_model (
  // Strobes from the bridge
  input  wire logic        clk,
  input  wire logic        output_enable_n,
  input  wire logic [1:0]  burst_count_bits,
  // Data towards the bridge
  output logic      [31:0] flash_data
);
  initial flash_data = 32'h0;
  // Data one clock after access; released bus toggles so late capture shows
  always @(posedge clk) begin
    if (!output_enable_n) begin
      flash_data <= {24'h5A5A5A, 6'h00, burst_count_bits};
    end else begin
      flash_data <= ~flash_data;
    end
  end
endmodule

/* tb/bfbi_top_test.sv */
`timescale 1ns/1ps
module bfbi_top_test;
  import bfbi_pkg::*;
  logic        clk, rst_n, cycle_start_strobe_n, write_not_read, last_beat_flag_n;
  logic        flash_select_n, read_ready, address_valid_strobe_n, output_enable_n;
  logic        write_enable_n, data_path_selector, beat_acknowledge_n;
  logic [3:0]  proc_addr_low;
  logic [2:0]  burst_latency_setting;
  logic [1:0]  burst_count_bits;
  logic [31:0] flash_data, read_data;
  int          n_errors, n_checks;

  bfbi_top uut (.clk(clk), .rst_n(rst_n), .cycle_start_strobe_n(cycle_start_strobe_n),
    .write_not_read(write_not_read), .last_beat_flag_n(last_beat_flag_n),
    .flash_select_n(flash_select_n), .proc_addr_low(proc_addr_low),
    .burst_latency_setting(burst_latency_setting), .flash_data(flash_data),
    .address_valid_strobe_n(address_valid_strobe_n), .burst_count_bits(burst_count_bits),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .data_path_selector(data_path_selector), .beat_acknowledge_n(beat_acknowledge_n),
    .read_data(read_data), .read_ready(read_ready));
  bfbi_flash_model u_flash (.clk(clk), .output_enable_n(output_enable_n),
    .burst_count_bits(burst_count_bits), .flash_data(flash_data));

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #5;
  endtask
  task automatic start_op(logic wr, logic [3:0] a, logic sel_n);
    cycle_start_strobe_n = 1'b0;
    write_not_read = wr;
    proc_addr_low = a;
    flash_select_n = sel_n;
    tick;
    cycle_start_strobe_n = 1'b1;
  endtask
  // Gap check skipped under stall: the buffer reshapes beat timing
  task automatic read_burst(logic [2:0] lat, logic [3:0] a, int n, int gap, int stall);
    int k, last, cyc;
    k = 0;
    last = 0;
    burst_latency_setting = lat;
    start_op(1'b0, a, 1'b0);
    check(burst_count_bits, a[3:2]);
    for (cyc = 0; cyc < 40; cyc++) begin
      last_beat_flag_n = (k < n - 1);
      read_ready = !(cyc >= 3 && cyc < 3 + stall);
      tick;
      if (beat_acknowledge_n === 1'b0) begin
        check(read_data[31:8], 32'h5A5A5A);
        if (k > 0 && stall == 0) check(cyc - last, gap);
        last = cyc;
        k++;
      end
    end
    check(k, n);
    flash_select_n = 1'b1;
    last_beat_flag_n = 1'b1;
  endtask
  task automatic abort_read(logic [3:0] a);
    start_op(1'b0, a, 1'b1);
    repeat (10) begin
      tick;
      check(beat_acknowledge_n, 1'b1);
    end
  endtask
  task automatic write_burst(logic [3:0] a, int n);
    int k, cyc;
    logic [1:0] c;
    logic prev;
    k = 0;
    c = a[3:2];
    prev = 1'b1;
    start_op(1'b1, a, 1'b0);
    for (cyc = 0; cyc < 12 * n; cyc++) begin
      last_beat_flag_n = (k < n);
      tick;
      if (write_enable_n === 1'b0 && prev) begin
        check(burst_count_bits, c);
        check(data_path_selector, 1'b1);
        c++;
        k++;
      end
      prev = write_enable_n;
    end
    check(k, n);
    flash_select_n = 1'b1;
    last_beat_flag_n = 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 3000);
    n_errors++;
    stop_test;
  end
  initial begin
    rst_n = 1'b0;
    cycle_start_strobe_n = 1'b1;
    write_not_read = 1'b0;
    last_beat_flag_n = 1'b1;
    flash_select_n = 1'b1;
    read_ready = 1'b1;
    proc_addr_low = 4'h0;
    burst_latency_setting = BFBI_LAT_INITIAL;
    n_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    #5 rst_n = 1'b1;
    read_burst(BFBI_LAT_INITIAL, 4'h4, 4, 2, 0);
    read_burst(BFBI_LAT_TWO, 4'hC, 4, 1, 0);
    read_burst(BFBI_LAT_ONE, 4'h0, 2, 1, 0);
    read_burst(BFBI_LAT_TWO, 4'h8, 4, 1, 6);
    abort_read(4'h4);
    write_burst(4'hC, 2);
    read_burst(BFBI_LAT_TWO, 4'h0, 1, 1, 0);
    stop_test;
  end
endmodule
